//--- pkg/tps_pkg.sv
`default_nettype none
package tps_pkg;
  localparam int DATA_W = 24;
  localparam int DLY_LEN = 16;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LINE = 8'h04;
  localparam logic [7:0] OFF_FRAME = 8'h08;
  localparam logic [7:0] OFF_SIZE = 8'h0C;
  localparam logic [7:0] OFF_POL = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  // control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_INV = 1;
  localparam int CTRL_DLY_LSB = 4;
  localparam int CTRL_DLY_W = 4;
  localparam int CTRL_DIV_LSB = 8;
  localparam int CTRL_DIV_W = 8;
  // timing register fields: pulse, back porch, front porch
  localparam int PW_LSB = 0;
  localparam int BP_LSB = 8;
  localparam int FP_LSB = 16;
  localparam int FIELD_W = 8;
  // size register fields: width low, height high
  localparam int WID_LSB = 0;
  localparam int HGT_LSB = 16;
  localparam int SIZE_FIELD_W = 16;
  // polarity register: set bit means active low
  localparam int POL_LINE = 0;
  localparam int POL_FRAME = 1;
  // status register fields
  localparam int STAT_LINE_LSB = 0;
  localparam int STAT_DE = 16;
  localparam int STAT_FSYNC = 17;
  localparam int STAT_FCNT_LSB = 24;
  // reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_LINE = 32'h0000_0000;
  localparam logic [31:0] RST_FRAME = 32'h0000_0000;
  localparam logic [31:0] RST_SIZE = 32'h0000_0000;
  localparam logic [1:0] RST_POL = 2'h0;

  typedef struct packed {
    logic pclk;
    logic line_sync;
    logic frame_sync;
    logic data_enable_out;
    logic [DATA_W-1:0] data;
  } tps_panel_t;

  typedef enum logic [1:0] {
    TPS_SYNC,
    TPS_BACK,
    TPS_ACTIVE,
    TPS_FRONT
  } tps_region_t;
endpackage
`default_nettype wire

//--- verilog/tps_timing.sv
// Function
// - line is sync pulse, back porch, active pixel data, front porch
// - line sync width and porches in pixel clocks, one line register
// - frame sync width and porches in whole lines, one frame register
// - active width and height share one active area size register
// - line and frame sync polarity selectable, active-high after reset
// - data enable is always active high, not configurable
// - data, syncs and data enable change on pixel clock rising edge; here they lead the uninverted, undelayed pclk rise by one system clock
// - pixel clock may be inverted and delayed via the control register invert and delay fields
//
// Local design decisions: the APB slave port and the address map.
`default_nettype none
module tps_timing #(
  parameter int PORCH_W = 8,
  parameter int SIZE_W = 12
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [tps_pkg::DATA_W-1:0] pixel_in,
  output logic pixel_take,
  output tps_pkg::tps_panel_t panel
);
  localparam int CNT_W = SIZE_W + 2;

  // refused at elaboration: fields must fit their register slots
  if (PORCH_W < 1 || PORCH_W > tps_pkg::FIELD_W) begin : g_bad_porch
    $error("PORCH_W out of range");
  end
  if (SIZE_W < 1 || SIZE_W > tps_pkg::SIZE_FIELD_W - 2) begin : g_bad_size
    $error("SIZE_W out of range");
  end

  logic [31:0] ctrl_ff;
  logic [31:0] line_timing_reg_ff;
  logic [31:0] frame_timing_reg_ff;
  logic [31:0] active_area_size_reg_ff;
  logic [1:0] polarity_select_reg_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [7:0] frame_cnt_ff;

  logic [CNT_W-1:0] h_cnt_ff;
  logic [CNT_W-1:0] v_cnt_ff;
  logic [tps_pkg::CTRL_DIV_W-1:0] div_cnt_ff;
  logic pclk_raw_ff;
  logic [tps_pkg::DLY_LEN-1:0] dly_ff;
  tps_pkg::tps_panel_t panel_ff;
  logic pixel_take_ff;

  wire logic wr_en = psel & penable & pready_ff & pwrite;
  wire logic setup = psel & ~penable;
  wire logic enable = ctrl_ff[tps_pkg::CTRL_EN];
  wire logic clk_inv = ctrl_ff[tps_pkg::CTRL_INV];
  wire logic [tps_pkg::CTRL_DLY_W-1:0] clk_dly =
    ctrl_ff[tps_pkg::CTRL_DLY_LSB +: tps_pkg::CTRL_DLY_W];
  wire logic [tps_pkg::CTRL_DIV_W-1:0] clk_div =
    ctrl_ff[tps_pkg::CTRL_DIV_LSB +: tps_pkg::CTRL_DIV_W];

  // timing fields widened to counter width
  logic [CNT_W-1:0] l_pw, l_bp, l_fp, f_pw, f_bp, f_fp, act_w, act_h;
  always_comb begin
    l_pw = CNT_W'(line_timing_reg_ff[tps_pkg::PW_LSB +: PORCH_W]);
    l_bp = CNT_W'(line_timing_reg_ff[tps_pkg::BP_LSB +: PORCH_W]);
    l_fp = CNT_W'(line_timing_reg_ff[tps_pkg::FP_LSB +: PORCH_W]);
    f_pw = CNT_W'(
      frame_timing_reg_ff[tps_pkg::PW_LSB +: PORCH_W]);
    f_bp = CNT_W'(frame_timing_reg_ff[tps_pkg::BP_LSB +: PORCH_W]);
    f_fp = CNT_W'(frame_timing_reg_ff[tps_pkg::FP_LSB +: PORCH_W]);
    act_w = CNT_W'(
      active_area_size_reg_ff[tps_pkg::WID_LSB +: SIZE_W]);
    act_h = CNT_W'(active_area_size_reg_ff[tps_pkg::HGT_LSB +: SIZE_W]);
  end

  // apb slave, zero wait states
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= tps_pkg::RST_CTRL;
      line_timing_reg_ff <= tps_pkg::RST_LINE;
      frame_timing_reg_ff <= tps_pkg::RST_FRAME;
      active_area_size_reg_ff <= tps_pkg::RST_SIZE;
      polarity_select_reg_ff <= tps_pkg::RST_POL;
    end else if (wr_en) begin
      case (paddr)
        tps_pkg::OFF_CTRL: ctrl_ff <= pwdata;
        tps_pkg::OFF_LINE: line_timing_reg_ff <= pwdata;
        tps_pkg::OFF_FRAME: frame_timing_reg_ff <= pwdata;
        tps_pkg::OFF_SIZE: active_area_size_reg_ff <= pwdata;
        tps_pkg::OFF_POL: polarity_select_reg_ff <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // read data and error are resolved in the setup cycle
  logic [31:0] rd_val;
  logic rd_hit;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      tps_pkg::OFF_CTRL: rd_val = ctrl_ff;
      tps_pkg::OFF_LINE: rd_val = line_timing_reg_ff;
      tps_pkg::OFF_FRAME: rd_val = frame_timing_reg_ff;
      tps_pkg::OFF_SIZE: rd_val = active_area_size_reg_ff;
      tps_pkg::OFF_POL: rd_val = {30'h0000_0000, polarity_select_reg_ff};
      tps_pkg::OFF_STAT: begin
        rd_val[tps_pkg::STAT_LINE_LSB +: CNT_W] = v_cnt_ff;
        rd_val[tps_pkg::STAT_DE] = panel_ff.data_enable_out;
        rd_val[tps_pkg::STAT_FSYNC] = panel_ff.frame_sync ^
          polarity_select_reg_ff[tps_pkg::POL_FRAME];
        rd_val[tps_pkg::STAT_FCNT_LSB +: 8] = frame_cnt_ff;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr_ff <= ~rd_hit;
    end
  end

  // pixel clock divider: half period is clk_div+1 system clocks
  wire logic div_end = (div_cnt_ff >= clk_div);
  wire logic tick = enable & div_end & ~pclk_raw_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_ff <= '0;
      pclk_raw_ff <= 1'b0;
    end else if (!enable) begin
      div_cnt_ff <= '0;
      pclk_raw_ff <= 1'b0;
    end else if (div_end) begin
      div_cnt_ff <= '0;
      pclk_raw_ff <= ~pclk_raw_ff;
    end else begin
      div_cnt_ff <= div_cnt_ff + 1'b1;
    end
  end

  // delay line of the raw pixel clock; tap chosen then optionally inverted
  logic pclk_tap;
  always_comb begin
    if (clk_dly == '0) begin
      pclk_tap = pclk_raw_ff;
    end else begin
      pclk_tap = dly_ff[clk_dly - 1'b1];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dly_ff <= '0;
    end else begin
      dly_ff <= {dly_ff[tps_pkg::DLY_LEN-2:0], pclk_raw_ff};
    end
  end

  // line and frame counters
  wire logic [CNT_W-1:0] h_total = l_pw + l_bp + act_w + l_fp;
  wire logic [CNT_W-1:0] v_total = f_pw + f_bp + act_h + f_fp;
  wire logic line_end = (h_cnt_ff + 1'b1 >= h_total);
  wire logic frame_end = (v_cnt_ff + 1'b1 >= v_total);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      h_cnt_ff <= '0;
      v_cnt_ff <= '0;
      frame_cnt_ff <= 8'h00;
    end else if (!enable) begin
      h_cnt_ff <= '0;
      v_cnt_ff <= '0;
    end else if (tick) begin
      if (line_end) begin
        h_cnt_ff <= '0;
        if (frame_end) begin
          v_cnt_ff <= '0;
          frame_cnt_ff <= frame_cnt_ff + 8'h01;
        end else begin
          v_cnt_ff <= v_cnt_ff + 1'b1;
        end
      end else begin
        h_cnt_ff <= h_cnt_ff + 1'b1;
      end
    end
  end

  // region decode
  tps_pkg::tps_region_t h_reg, v_reg;
  always_comb begin
    if (h_cnt_ff < l_pw) begin
      h_reg = tps_pkg::TPS_SYNC;
    end else if (h_cnt_ff < l_pw + l_bp) begin
      h_reg = tps_pkg::TPS_BACK;
    end else if (h_cnt_ff < l_pw + l_bp + act_w) begin
      h_reg = tps_pkg::TPS_ACTIVE;
    end else begin
      h_reg = tps_pkg::TPS_FRONT;
    end
    if (v_cnt_ff < f_pw) begin
      v_reg = tps_pkg::TPS_SYNC;
    end else if (v_cnt_ff < f_pw + f_bp) begin
      v_reg = tps_pkg::TPS_BACK;
    end else if (v_cnt_ff < f_pw + f_bp + act_h) begin
      v_reg = tps_pkg::TPS_ACTIVE;
    end else begin
      v_reg = tps_pkg::TPS_FRONT;
    end
  end

  logic active;
  always_comb begin
    case (h_reg)
      tps_pkg::TPS_ACTIVE: active = (v_reg == tps_pkg::TPS_ACTIVE);
      default: active = 1'b0;
    endcase
  end

  // panel outputs; undelayed, uninverted pclk lags data by one system clock for setup margin
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      panel_ff <= '0;
      pixel_take_ff <= 1'b0;
    end else begin
      panel_ff.pclk <= pclk_tap ^ clk_inv;
      pixel_take_ff <= tick & active;
      if (!enable) begin
        panel_ff.line_sync <= polarity_select_reg_ff[tps_pkg::POL_LINE];
        panel_ff.frame_sync <= polarity_select_reg_ff[tps_pkg::POL_FRAME];
        panel_ff.data_enable_out <= 1'b0;
        panel_ff.data <= '0;
      end else if (tick) begin
        panel_ff.line_sync <= (h_reg == tps_pkg::TPS_SYNC) ^
          polarity_select_reg_ff[tps_pkg::POL_LINE];
        panel_ff.frame_sync <= (v_reg == tps_pkg::TPS_SYNC) ^
          polarity_select_reg_ff[tps_pkg::POL_FRAME];
        panel_ff.data_enable_out <= active;
        panel_ff.data <= active ? pixel_in : '0;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pixel_take = pixel_take_ff;
  assign panel = panel_ff;
endmodule
`default_nettype wire

//--- sim/tps_timing_assertions.sv
`default_nettype none
module tps_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [tps_pkg::DATA_W-1:0] pixel_in,
  input wire logic pixel_take,
  input wire tps_pkg::tps_panel_t panel
);
  logic en_ff;
  logic [1:0] pol_ff;
  logic wr;
  // shadow copies, so idle levels can be judged without peeking inside
  assign wr = psel && penable && pready && pwrite;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      en_ff <= 1'h0;
      pol_ff <= tps_pkg::RST_POL;
    end else if (wr && paddr == tps_pkg::OFF_CTRL) begin
      en_ff <= pwdata[tps_pkg::CTRL_EN];
    end else if (wr && paddr == tps_pkg::OFF_POL) begin
      pol_ff <= pwdata[1:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  chk_ready_up: assert property ($past(rst_b) |-> pready)
    else $error("pready low after reset");
  chk_unmapped_err: assert property (psel && penable &&
    paddr > tps_pkg::OFF_STAT |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_write_zero: assert property (psel && penable && pwrite |->
    prdata == 32'h0) else $error("write returned data");
  chk_take_pulse: assert property (pixel_take |=> !pixel_take)
    else $error("pixel take longer than one cycle");
  chk_take_de: assert property (pixel_take |-> panel.data_enable_out)
    else $error("pixel taken outside data enable");
  chk_take_data: assert property (pixel_take |->
    panel.data == $past(pixel_in)) else $error("pixel data mismatch");
  chk_idle_de: assert property (!en_ff [*3] |->
    !panel.data_enable_out && !pixel_take) else $error("active while off");
  chk_idle_sync: assert property ((!en_ff && $stable(pol_ff)) [*3] |->
    panel.line_sync == pol_ff[0] && panel.frame_sync == pol_ff[1])
    else $error("sync not at idle level");
endmodule
bind tps_timing tps_chk u_chk (.clock(clock), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pixel_in(pixel_in), .pixel_take(pixel_take), .panel(panel));
`default_nettype wire

//--- sim/tps_panel_model.sv
`default_nettype none
module tps_panel_model (
  input wire tps_pkg::tps_panel_t panel,
  input wire logic [1:0] pol,
  output logic [15:0] line_len,
  output logic [15:0] sync_len,
  output logic [15:0] de_len,
  output logic [15:0] frame_lines
);
  logic hs, hs_q, fs, fs_q;
  logic [15:0] pc, sc, dc, lc;
  assign hs = panel.line_sync ^ pol[0];
  assign fs = panel.frame_sync ^ pol[1];
  // panel samples on its own clock only, as a real glass would
  always @(posedge panel.pclk) begin
    hs_q <= hs;
    fs_q <= fs;
    pc <= (hs && !hs_q) ? 16'h1 : pc + 16'h1;
    if (hs && !hs_q) line_len <= pc;
    sc <= hs ? sc + 16'h1 : 16'h0;
    if (!hs && hs_q) sync_len <= sc;
    dc <= panel.data_enable_out ? dc + 16'h1 : 16'h0;
    if (!panel.data_enable_out && dc != 16'h0) de_len <= dc;
    if (hs && !hs_q) lc <= (fs && !fs_q) ? 16'h1 : lc + 16'h1;
    if (fs && !fs_q) frame_lines <= lc;
  end
endmodule
`default_nettype wire

//--- sim/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic pixel_take, pclk_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] wv [4];
  logic [tps_pkg::DATA_W-1:0] pixel_in;
  tps_pkg::tps_panel_t panel;
  logic [15:0] line_len, sync_len, de_len, frame_lines, clk_cnt, pclk_per;
  logic [1:0] pol;
  int err_total, comparisons;
  int pw, bp, fp, w, h, vpw, vbp, vfp, div, dly, inv;
  tps_timing dut (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixel_in(pixel_in), .pixel_take(pixel_take), .panel(panel));
  tps_panel_model model (.panel(panel), .pol(pol), .line_len(line_len),
    .sync_len(sync_len), .de_len(de_len), .frame_lines(frame_lines));
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  // pixel source presents the next pixel once the last one is taken
  always @(posedge clock) begin
    if (pixel_take) pixel_in <= 24'($urandom);
    pclk_q <= panel.pclk;
    clk_cnt <= (panel.pclk && !pclk_q) ? 16'h1 : clk_cnt + 16'h1;
    if (panel.pclk && !pclk_q) pclk_per <= clk_cnt;
  end
  function automatic logic [31:0] tword(input int a, b, c);
    return 32'(a << tps_pkg::PW_LSB | b << tps_pkg::BP_LSB |
      c << tps_pkg::FP_LSB);
  endfunction
  function automatic logic [15:0] span(input int a, b, c, d);
    return 16'(a + b + c + d);
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cmp32(input logic [31:0] g, e, input string m);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t %s got %h", $time, m, g);
    end
  endtask
  task automatic cmp16(input logic [15:0] g, e, input string m);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t %s got %0d", $time, m, g);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    err_total++;
    report_and_stop;
  end
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, pixel_in} = '0;
    {pol, err_total, comparisons} = '0;
    void'($urandom(32'hAEE5421A));
    repeat (5) @(posedge clock);
    rst_b <= 1'h1;
    wv = '{tps_pkg::RST_CTRL, tps_pkg::RST_LINE, tps_pkg::RST_FRAME,
      tps_pkg::RST_SIZE};
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, 8'(i * 4), 32'h0);
      cmp32(rd, wv[i], "reset value");
    end
    apb(1'h0, tps_pkg::OFF_POL, 32'h0);
    cmp32(rd, {30'h0, tps_pkg::RST_POL}, "polarity reset");
    apb(1'h1, 8'h18, 32'hFFFFFFFF);
    cmp32({31'h0, err}, 32'h1, "unmapped refused");
    $display("test registers done");
    for (int it = 0; it < 4; it++) begin
      {pw, bp, fp} = {1 + $urandom % 3, 1 + $urandom % 3, 1 + $urandom % 3};
      {w, h} = {1 + $urandom % 8, 1 + $urandom % 3};
      {vpw, vbp, vfp} = {1 + $urandom % 2, 1 + $urandom % 2, 1 + $urandom % 2};
      if (it == 0) begin
        pw = 1;
        bp = 1;
        fp = 1;
        w = 1;
        h = 1;
      end
      div = 1 + $urandom % 2;
      inv = $urandom % 2;
      // a delay of a whole half period would race the next pixel update
      dly = $urandom % div;
      pol = 2'($urandom);
      wv = '{tword(pw, bp, fp), tword(vpw, vbp, vfp),
        32'(w | h << tps_pkg::HGT_LSB), {30'h0, pol}};
      for (int i = 0; i < 4; i++) begin
        apb(1'h1, 8'(4 + i * 4), wv[i]);
        apb(1'h0, 8'(4 + i * 4), 32'h0);
        cmp32(rd, wv[i], "readback");
      end
      apb(1'h1, tps_pkg::OFF_CTRL, 32'(1 | inv << tps_pkg::CTRL_INV |
        dly << tps_pkg::CTRL_DLY_LSB | div << tps_pkg::CTRL_DIV_LSB));
      repeat (3 * span(vpw, vbp, vfp, h) * span(pw, bp, w, fp) *
        2 * (div + 1) + 50) @(posedge clock);
      cmp16(line_len, span(pw, bp, w, fp), "line length");
      cmp16(sync_len, 16'(pw), "line sync width");
      cmp16(de_len, 16'(w), "active width");
      cmp16(frame_lines, span(vpw, vbp, vfp, h), "frame");
      cmp16(pclk_per, 16'(2 * (div + 1)), "pixel clock");
      apb(1'h1, tps_pkg::OFF_CTRL, 32'h0);
      repeat (10) @(posedge clock);
      // disabled: line count cleared, no data enable, frame sync inactive
      apb(1'h0, tps_pkg::OFF_STAT, 32'h0);
      cmp32(rd & 32'h00FF_FFFF, 32'h0, "status idle");
      $display("test timing %0d done", it);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
